// >>> rtl/wksts_pkg.sv
// Purpose: Constants for the wake-status register bank
// Assumes: 8-bit runtime register port, offsets relative to block base
// Notes:   Status registers reset to zero only on standby power-on reset
package wksts_pkg;
    localparam int unsigned WKSTS_DATA_W    = 8;
    localparam int unsigned WKSTS_OFFS_W    = 8;
    localparam int unsigned WKSTS_NUM_REGS  = 4;
    localparam int unsigned WKSTS_NUM_SRC   = 32;
    localparam int unsigned WKSTS_SYNC_W    = 2;
    localparam logic [7:0] WKSTS_OFFS_STS2  = 8'h05;
    localparam logic [7:0] WKSTS_OFFS_STS3  = 8'h06;
    localparam logic [7:0] WKSTS_OFFS_STS4  = 8'h07;
    localparam logic [7:0] WKSTS_OFFS_STS5  = 8'h08;
    localparam logic [7:0] WKSTS_RESET_VAL  = 8'h00;
    localparam int unsigned WKSTS_GROUP_BIT = 3;
    localparam logic [7:0] WKSTS_RSVD_READ  = 8'h00;
endpackage

// >>> rtl/wksts_edge_sync.sv
// Purpose: Two-flop synchroniser and rising-edge detector for one wake pin
// Assumes: Pin is asynchronous to clk
// Notes:   First flop feeds only the second flop
`timescale 1ns/1ps
module wksts_edge_sync
    import wksts_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Pin and event
    input  wire logic pin_in,
    output logic      event_pulse
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
        logic evt;
    } wksts_sync_t;

    wksts_sync_t s_q;
    wksts_sync_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.meta = pin_in;
        s_d.sync = s_q.meta;
        s_d.last = s_q.sync;
        s_d.evt  = s_q.sync & ~s_q.last;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign event_pulse = s_q.evt;
endmodule

// >>> rtl/wksts_regs.sv
// Purpose: Wake-status registers two to five with wake output
// Assumes: Host register port is a plain strobe port on the runtime block
// Notes:   reset is the standby power-on reset; other resets do not reach here
//          Read data shows the status as it stood when the read was taken
//          A wake event in the cycle of a clearing write keeps its bit set
//          A pin pulse shorter than one clock may be missed by the synchroniser
//          Only the rising edge of a source counts as a wake event
//
// Overview of operation
// - Status ignores per-source and global enables
// - Wake event sets its status bit
// - Standby power-on reset clears all to zero
// - Main, soft, hard resets leave status alone
// - Write one clears bits of registers two-four
// - Writing zero leaves bit unchanged
// - Register two offset 05: pins 10-17
// - Register three: 20-22, group SMI, 24-27
// - Register four: 30-33,41,43,60,61
// - Register five offset 08: pins 50-57
// - Register five also write-one-to-clear
// - Wake output low when status, enable, global
// - Decode at fixed offsets from base
`timescale 1ns/1ps
module wksts_regs
    import wksts_pkg::*;
(
    // Clock and standby power-on reset
    input  wire logic                    clk,
    input  wire logic                    reset,
    // Host register port
    input  wire logic                    reg_sel,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire logic [WKSTS_OFFS_W-1:0] reg_offset,
    input  wire logic [WKSTS_DATA_W-1:0] reg_wdata,
    output logic      [WKSTS_DATA_W-1:0] reg_rdata,
    // Wake sources
    input  wire logic [7:0]              gp1x_pins,
    input  wire logic [7:0]              gp2x_pins,
    input  wire logic [7:0]              gp3x_misc_pins,
    input  wire logic [7:0]              gp5x_pins,
    input  wire logic                    group_smi_wake_status,
    // Enables held outside this block
    input  wire logic [31:0]             wake_source_enable,
    input  wire logic                    global_wake_enable,
    // Status and wake output
    output logic [31:0]                  wake_status_all,
    output logic                         wake_request_out_n
);
    typedef struct packed {
        logic [3:0][7:0] status;
        logic [7:0]      rdata;
        logic            wake_n;
        logic            smi_last;
    } wksts_state_t;

    wksts_state_t st_q;
    wksts_state_t st_d;

    logic [31:0] pin_vec;
    logic [31:0] evt_vec;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;

    logic [WKSTS_NUM_REGS-1:0]                   wr_lane;
    logic [WKSTS_NUM_REGS-1:0]                   rd_lane;
    logic [WKSTS_NUM_REGS-1:0]                   wake_lane;
    logic [WKSTS_NUM_REGS-1:0][WKSTS_DATA_W-1:0] rd_term;
    logic [WKSTS_NUM_SRC-1:0]                    next_status;
    logic [WKSTS_DATA_W-1:0]                     rd_any;
    logic                                        wr_hit;
    logic                                        rd_hit;
    logic                                        wake_any;

    // ========================================
    // Elaboration checks
    // ========================================
    // Lanes are byte wide and must cover the source vector exactly
    if (WKSTS_DATA_W != 8) begin : g_bad_data_w
        $error("wksts_regs: register width must be 8");
    end
    if (WKSTS_NUM_REGS != 4) begin : g_bad_num_regs
        $error("wksts_regs: the offset decode serves exactly four registers");
    end
    if (WKSTS_NUM_REGS * WKSTS_DATA_W != WKSTS_NUM_SRC) begin : g_bad_num_src
        $error("wksts_regs: source count must fill the registers exactly");
    end
    if (WKSTS_GROUP_BIT >= WKSTS_DATA_W) begin : g_bad_group_bit
        $error("wksts_regs: group bit must lie inside register three");
    end
    if (WKSTS_OFFS_W != 8) begin : g_bad_offs_w
        $error("wksts_regs: offset decode expects an 8-bit offset");
    end

    // Returns register index for an offset, or 3'h4 if unmapped
    function automatic logic [2:0] wksts_decode(input logic [7:0] offs);
        case (offs)
            WKSTS_OFFS_STS2: wksts_decode = 3'h0;
            WKSTS_OFFS_STS3: wksts_decode = 3'h1;
            WKSTS_OFFS_STS4: wksts_decode = 3'h2;
            WKSTS_OFFS_STS5: wksts_decode = 3'h3;
            default:         wksts_decode = 3'h4;
        endcase
    endfunction

    // True when the offset names one of the status registers
    function automatic logic wksts_mapped(input logic [7:0] offs);
        wksts_mapped = (wksts_decode(offs) != 3'h4);
    endfunction

    // One-hot lane for a mapped offset, all zero otherwise
    function automatic logic [3:0] wksts_lane(input logic [7:0] offs);
        logic [2:0] idx;
        idx        = wksts_decode(offs);
        wksts_lane = 4'h0;
        if (idx != 3'h4) begin
            wksts_lane[idx[1:0]] = 1'b1;
        end
    endfunction

    // OR of the read terms; at most one is non-zero
    function automatic logic [7:0] wksts_or_lanes(input logic [3:0][7:0] terms);
        wksts_or_lanes = 8'h00;
        for (int i = 0; i < 4; i++) begin
            wksts_or_lanes = wksts_or_lanes | terms[i];
        end
    endfunction

    // ========================================
    // Host access decode
    // ========================================
    assign wr_hit  = reg_sel & reg_wr & wksts_mapped(reg_offset);
    assign rd_hit  = reg_sel & reg_rd & wksts_mapped(reg_offset);
    assign wr_lane = wr_hit ? wksts_lane(reg_offset) : 4'h0;
    assign rd_lane = rd_hit ? wksts_lane(reg_offset) : 4'h0;

    // ========================================
    // Source mapping and synchronisers
    // ========================================
    // Bit 11 (register three bit 3) is the group SMI level, not a pin
    assign pin_vec = {gp5x_pins, gp3x_misc_pins, gp2x_pins, gp1x_pins};

    genvar gi;
    generate
        for (gi = 0; gi < WKSTS_NUM_SRC; gi++) begin : g_src
            if (gi == 8 + WKSTS_GROUP_BIT) begin : g_smi
                assign evt_vec[gi] = group_smi_wake_status & ~st_q.smi_last;
            end else begin : g_pin
                wksts_edge_sync u_sync (
                    .clk         (clk),
                    .reset       (reset),
                    .pin_in      (pin_vec[gi]),
                    .event_pulse (evt_vec[gi])
                );
            end
        end
    endgenerate

    // ========================================
    // Per-register lanes
    // ========================================
    // Clear mask and read term for each byte-wide register
    genvar gr;
    generate
        for (gr = 0; gr < WKSTS_NUM_REGS; gr++) begin : g_lane
            assign clr_vec[gr*8 +: 8] = wr_lane[gr] ? reg_wdata : 8'h00;
            assign rd_term[gr]        = rd_lane[gr] ? st_q.status[gr] : 8'h00;
        end
    endgenerate

    assign rd_any = wksts_or_lanes(rd_term);

    // ========================================
    // Wake output
    // ========================================
    // Looks at the next status so the output drops in the cycle a clear lands
    generate
        for (gr = 0; gr < WKSTS_NUM_REGS; gr++) begin : g_wake
            assign wake_lane[gr] = |(next_status[gr*8 +: 8] &
                                     wake_source_enable[gr*8 +: 8]);
        end
    endgenerate

    assign wake_any = |wake_lane;

    // ========================================
    // Register update
    // ========================================
    // Events are or-ed in after the clear, so a same-cycle event survives
    assign set_vec     = evt_vec;
    assign next_status = (st_q.status & ~clr_vec) | set_vec;

    always_comb begin
        st_d          = st_q;
        st_d.smi_last = group_smi_wake_status;
        st_d.status   = next_status;
        st_d.rdata    = rd_hit ? rd_any : WKSTS_RSVD_READ;
        st_d.wake_n   = ~(global_wake_enable & wake_any);
    end

    // ========================================
    // State register
    // ========================================
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q.status   <= {WKSTS_NUM_REGS{WKSTS_RESET_VAL}};
            st_q.rdata    <= WKSTS_RSVD_READ;
            st_q.wake_n   <= 1'b1;
            st_q.smi_last <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ========================================
    // Outputs
    // ========================================
    assign reg_rdata          = st_q.rdata;
    assign wake_status_all    = st_q.status;
    assign wake_request_out_n = st_q.wake_n;
endmodule

// >>> test/wksts_checker.sv
// Purpose: Assertions on the wake-status bank ports
// Assumes: Bench holds pins steady during writes
// Notes:   Bound to wksts_regs
`timescale 1ns/1ps
module wksts_checker
    import wksts_pkg::*;
(
    input wire logic        clk, reset, reg_sel, reg_wr, reg_rd, global_wake_enable,
    input wire logic        group_smi_wake_status, wake_request_out_n,
    input wire logic [7:0]  reg_offset, reg_wdata, reg_rdata, gp1x_pins,
    input wire logic [31:0] wake_status_all, wake_source_enable
);
    // ========
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire wr = reg_sel && reg_wr;
    wire rd = reg_sel && reg_rd;
    property p_rst; $fell(reset) |-> wake_status_all == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("status not zero");
    property p_smi; $rose(group_smi_wake_status) |=> wake_status_all[11]; endproperty
    a_smi: assert property (p_smi) else $error("group bit not set");
    property p_stick; |($past(wake_status_all) & ~wake_status_all)
        |-> $past(wr && reg_offset inside {[8'h05:8'h08]}); endproperty
    a_stick: assert property (p_stick) else $error("bit fell without write");
    property p_wake; wake_request_out_n == !(|(wake_status_all & $past(wake_source_enable))
        && $past(global_wake_enable)); endproperty
    a_wake: assert property (p_wake) else $error("wake output wrong");
    property p_clr5; wr && reg_offset == 8'h05 |=> !(|(wake_status_all[7:0] & $past(reg_wdata)));
    endproperty
    a_clr5: assert property (p_clr5) else $error("clear failed");
    property p_clr8; wr && reg_offset == 8'h08 |=> !(|(wake_status_all[31:24] & $past(reg_wdata)));
    endproperty
    a_clr8: assert property (p_clr8) else $error("clear failed");
    property p_rd; rd && reg_offset == 8'h06 |=> reg_rdata == $past(wake_status_all[15:8]);
    endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    property p_idle; !rd |=> reg_rdata == 8'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data not zero");
    property p_pin; $rose(gp1x_pins[0]) |-> ##[1:5] wake_status_all[0]; endproperty
    a_pin: assert property (p_pin) else $error("pin event lost");
endmodule
bind wksts_regs wksts_checker wksts_checker_inst (.clk, .reset, .reg_sel, .reg_wr, .reg_rd,
    .global_wake_enable, .group_smi_wake_status, .wake_request_out_n, .reg_offset, .reg_wdata,
    .reg_rdata, .gp1x_pins, .wake_status_all, .wake_source_enable);

// >>> test/testbench.sv
// Purpose: Self-checking bench for the wake-status bank
// Assumes: Pins held steady around writes
// Notes:   Read results checked through a queue
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module testbench
    import wksts_pkg::*;
;
    // ========
    // Stimulus and checks
    logic        clk = 0, reset = 1, reg_sel = 0, reg_wr = 0, reg_rd = 0, rd_q = 0;
    logic        global_wake_enable = 0, group_smi_wake_status = 0, wake_request_out_n;
    logic [7:0]  reg_offset = 0, reg_wdata = 0, reg_rdata, exp_v, exp_q[$];
    logic [7:0]  gp1x_pins = 0, gp2x_pins = 0, gp3x_misc_pins = 0, gp5x_pins = 0;
    logic [31:0] wake_source_enable = 0, wake_status_all, pins, w;
    int          err_count = 0, n_compared = 0;
    wksts_regs wksts_regs_inst (.clk, .reset, .reg_sel, .reg_wr, .reg_rd, .reg_offset,
        .reg_wdata, .reg_rdata, .gp1x_pins, .gp2x_pins, .gp3x_misc_pins, .gp5x_pins,
        .group_smi_wake_status, .wake_source_enable, .global_wake_enable, .wake_status_all,
        .wake_request_out_n);
    always #12.5 clk = ~clk;
    task automatic acc(input logic wr, input logic [7:0] off, input logic [7:0] d);
        @(posedge clk) #1;
        {reg_sel, reg_wr, reg_rd, reg_offset, reg_wdata} = {1'b1, wr, !wr, off, d};
        if (!wr) exp_q.push_back(d);
        @(posedge clk) #1;
        {reg_sel, reg_wr, reg_rd} = 3'b000;
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        if (rd_q && exp_q.size() > 0) begin
            exp_v = exp_q.pop_front();
            `CHK(reg_rdata, exp_v)
        end
        rd_q <= reg_sel & reg_rd;
    end
    initial begin
        #50000;
        err_count++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'hcfe1));
        repeat (16) @(posedge clk);
        #1 reset = 0;
        for (int i = 0; i < 5; i++) acc(0, 8'h05 + i, 8'h00);
        $display("reset test done");
        pins = $urandom();
        {gp5x_pins, gp3x_misc_pins, gp2x_pins, gp1x_pins} = pins;
        pins[11] = 0;
        repeat (6) @(posedge clk);
        #1 `CHK(wake_status_all, pins)
        for (int i = 0; i < 4; i++) acc(0, 8'h05 + i, pins[8*i+:8]);
        $display("event test done");
        w = $urandom();
        for (int i = 0; i < 4; i++) acc(1, 8'h05 + i, w[8*i+:8]);
        acc(1, 8'h09, 8'hff);
        pins &= ~w;
        for (int i = 0; i < 4; i++) acc(0, 8'h05 + i, pins[8*i+:8]);
        $display("clear test done");
        {wake_source_enable, global_wake_enable, group_smi_wake_status} = {32'h800, 2'b11};
        pins[11] = 1;
        repeat (3) @(posedge clk);
        #1 `CHK(wake_request_out_n, 1'b0)
        acc(0, 8'h06, pins[15:8]);
        acc(1, 8'h06, 8'h08);
        `CHK(wake_request_out_n, 1'b1)
        group_smi_wake_status = 0;
        fork
            acc(1, 8'h06, 8'h08);
            begin @(posedge clk) #1 group_smi_wake_status = 1; end
        join
        acc(0, 8'h06, pins[15:8]);
        `CHK(wake_request_out_n, 1'b0)
        $display("wake test done");
        {gp5x_pins, gp3x_misc_pins, gp2x_pins, gp1x_pins} = 32'h0;
        group_smi_wake_status = 0;
        repeat (2) @(posedge clk);
        #1 reset = 1;
        repeat (2) @(posedge clk);
        #1 reset = 0;
        `CHK(wake_status_all, 32'h0)
        `CHK(wake_request_out_n, 1'b1)
        for (int i = 0; i < 4; i++) acc(0, 8'h05 + i, 8'h00);
        $display("second reset test done");
        repeat (2) @(posedge clk);
        end_of_test();
    end
endmodule
